// [design/hltm_defines.vh]
// Purpose: constants of the hardware limit timer block (offsets, fields, resets, modes, timing)
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one register per aligned word
// Notes:   included by bare name by every design file that needs it
`ifndef HLTM_DEFINES_VH
`define HLTM_DEFINES_VH

// register byte offsets
`define HLTM_OFS_CTRL        5'h00
`define HLTM_OFS_MODE        5'h04
`define HLTM_OFS_COUNT       5'h08
`define HLTM_OFS_PERIOD      5'h0C
`define HLTM_OFS_CLKSEL      5'h10
`define HLTM_OFS_STATUS      5'h14

// field positions
`define HLTM_CTRL_RUN_BIT    7
`define HLTM_CTRL_POST_MSB   3
`define HLTM_MODE_PRESCALER_SYNC_SELECT_BIT  7
`define HLTM_MODE_MSB        3
`define HLTM_MODE_ONESHOT    3
`define HLTM_CLKSEL_MSB      2

// reset values
`define HLTM_RST_COUNT       8'h00
`define HLTM_RST_PERIOD      8'hFF
`define HLTM_RST_MODE        4'h0
`define HLTM_RST_POST        4'h0
`define HLTM_RST_CLKSEL      3'h0

// control mode codes
`define HLTM_M_SW_GATE       4'h0
`define HLTM_M_GATE_HI_STOP  4'h1
`define HLTM_M_GATE_LO_STOP  4'h2
`define HLTM_M_LIM_ANY       4'h3
`define HLTM_M_LIM_RISE      4'h4
`define HLTM_M_LIM_FALL      4'h5
`define HLTM_M_LIM_LVL_LO    4'h6
`define HLTM_M_LIM_LVL_HI    4'h7
`define HLTM_M_OS_SW         4'h8
`define HLTM_M_OS_RISE       4'h9
`define HLTM_M_OS_FALL       4'hA
`define HLTM_M_OS_ANY        4'hB
`define HLTM_M_OSL_RISE      4'hC
`define HLTM_M_OSL_FALL      4'hD
`define HLTM_M_OSV_HI        4'hE
`define HLTM_M_OSV_LO        4'hF

// edge kinds for the edge selector
`define HLTM_EDGE_ANY        2'h0
`define HLTM_EDGE_RISE       2'h1
`define HLTM_EDGE_FALL       2'h2

// timer clock source codes that are internal oscillators
`define HLTM_CS_HFOSC        3'h2
`define HLTM_CS_LFOSC        3'h3
`define HLTM_CS_MFOSC        3'h5

// timing counts, in timer clock ticks
`define HLTM_RESTART_TICKS   2'h2

`endif

// [design/hltm_sync2.v]
// Purpose: two flip-flop level synchroniser for signals from outside the clock domain
// Assumes: inputs are levels that stay at least two clk periods
// Notes:   the first stage feeds only the second stage
`timescale 1ns/100ps
module hltm_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // plain double register, cleared by reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // hltm_sync2

// [design/hltm_timer.v]
// Purpose: 8-bit period timer with hardware limit modes, reached over Avalon-MM
// Assumes: timer_clock, ext_reset_input and sleep_active are asynchronous pins;
//          timer clock high and low phases each last at least two clk periods
// Notes:   one timer clock rising edge is one timer tick; everything counts ticks
//
// Summary of operation
// - software gate: run bit set counts, clear holds
// - count equal period clears on next tick
// - mode 0001: external high suspends counting
// - mode 0010: external low suspends counting
// - modes 0011/0100/0101: selected edge clears count
// - modes 0110/0111: count held at selected level
// - run bit clear ignores external signal
// - mode 1000: match clears count and run
// - modes 1001-1011: selected edge starts one shot
// - halted edge one-shot needs new edge
// - modes 1100/1101: first edge starts, later reset
// - after edge reset, restart two ticks later
// - edges before run set ignored; match stops
// - modes 1110/1111: level holds, release starts
// - level one-shot: match stops, rerun needs edge
// - run takes two ticks sync, external one tick
// - prescaler_sync_select set: frozen during sleep, values kept
// - prescaler_sync_select clear: counts in sleep with clock
// - internal oscillator source kept running in sleep
// - mode top bit selects one-shot behaviour
// - match pulse lasts one timer clock period
// - reset: count zero, period all ones
`timescale 1ns/100ps
`include "hltm_defines.vh"
module hltm_timer (
    input  wire        clk,
    input  wire        nrst,
    input  wire [4:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output wire [31:0] readdata,
    output wire        waitrequest,
    input  wire        timer_clock,
    input  wire        ext_reset_input,
    input  wire        sleep_active,
    output wire [7:0]  timer_count,
    output wire        period_match_pulse,
    output wire        osc_keep_running
);

    // edge selector shared by every edge-driven mode
    function edge_hit;
        input [1:0] kind;
        input       rise;
        input       fall;
        begin
            case (kind)
                `HLTM_EDGE_RISE: edge_hit = rise;
                `HLTM_EDGE_FALL: edge_hit = fall;
                default:         edge_hit = rise | fall;
            endcase
        end
    endfunction

    // internal oscillator sources, used for the sleep keep-alive request
    function is_int_osc;
        input [2:0] sel;
        begin
            is_int_osc = (sel == `HLTM_CS_HFOSC) || (sel == `HLTM_CS_LFOSC) ||
                         (sel == `HLTM_CS_MFOSC);
        end
    endfunction

    reg         rst_s1_q;
    reg         rst_s2_q;
    wire        rst_n;
    wire [2:0]  pins_s;
    reg         tclk_prev_q;
    wire        tick;
    wire        tick_en;
    wire        sleep_s;
    reg         run_q;
    reg         run_p1_q;
    reg         run_p2_q;
    wire        run_eff;
    reg         ers_a_q;
    reg         ers_b_q;
    wire        ers_rise;
    wire        ers_fall;
    reg  [7:0]  count_q;
    reg  [7:0]  count_d;
    reg  [7:0]  period_q;
    reg  [3:0]  mode_q;
    reg         prescaler_sync_select_q;
    reg  [3:0]  post_sel_q;
    reg  [3:0]  post_cnt_q;
    reg  [2:0]  clk_sel_q;
    reg         started_q;
    reg         started_d;
    reg  [1:0]  hold_q;
    reg  [1:0]  hold_d;
    reg         hw_stop;
    reg         match_evt;
    reg         pulse_q;
    reg         keep_osc_q;
    reg         wait_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    wire        access;
    wire        wr_en;
    wire        wr_ctrl;
    wire        wr_count;
    wire [7:0]  count_inc;

    // reset release through two flip-flops; the rest of the block uses rst_n
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // all three pins pass two flip-flops before any logic looks at them
    hltm_sync2 #(
        .WIDTH    (3)
    ) u_pin_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({sleep_active, ext_reset_input, timer_clock}),
        .sync_out (pins_s)
    );

    assign sleep_s = pins_s[2];

    // a tick is a rising timer clock edge seen after synchronisation
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tclk_prev_q <= 1'b0;
        end else begin
            tclk_prev_q <= pins_s[0];
        end
    end
    assign tick    = pins_s[0] & ~tclk_prev_q;
    // with prescaler sync selected the timer is frozen while asleep
    assign tick_en = tick & ~(sleep_s & prescaler_sync_select_q);

    // external signal sampled on ticks; edges compare two tick samples
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ers_a_q <= 1'b0;
            ers_b_q <= 1'b0;
        end else if (tick_en) begin
            ers_a_q <= pins_s[1];
            ers_b_q <= ers_a_q;
        end
    end
    assign ers_rise = ers_a_q & ~ers_b_q;
    assign ers_fall = ~ers_a_q & ers_b_q;

    // bus decode: a request is taken in the cycle where waitrequest is low
    assign access   = (read | write) & ~wait_q;
    assign wr_en    = write & ~wait_q & byteenable[0];
    assign wr_ctrl  = wr_en & (address == `HLTM_OFS_CTRL);
    assign wr_count = wr_en & (address == `HLTM_OFS_COUNT);
    assign count_inc = count_q + 8'h01;

    // tick-level sequencing of the count for all sixteen modes
    always @* begin
        count_d   = count_q;
        started_d = started_q;
        hold_d    = hold_q;
        hw_stop   = 1'b0;
        match_evt = 1'b0;
        if (tick_en) begin
            if (!run_eff) begin
                // stopped: count holds, external signal is ignored, triggers rearm
                started_d = 1'b0;
                hold_d    = 2'h0;
            end else if (count_q == period_q) begin
                count_d   = `HLTM_RST_COUNT;
                match_evt = 1'b1;
                if (mode_q[`HLTM_MODE_ONESHOT]) begin
                    hw_stop   = 1'b1;
                    started_d = 1'b0;
                end
            end else begin
                case (mode_q)
                    `HLTM_M_GATE_HI_STOP: begin
                        if (!ers_a_q) count_d = count_inc;
                    end
                    `HLTM_M_GATE_LO_STOP: begin
                        if (ers_a_q) count_d = count_inc;
                    end
                    `HLTM_M_LIM_ANY, `HLTM_M_LIM_RISE, `HLTM_M_LIM_FALL: begin
                        if (edge_hit(mode_q[1:0] - 2'h3, ers_rise, ers_fall))
                            count_d = `HLTM_RST_COUNT;
                        else
                            count_d = count_inc;
                    end
                    `HLTM_M_LIM_LVL_LO: begin
                        count_d = ers_a_q ? count_inc : `HLTM_RST_COUNT;
                    end
                    `HLTM_M_LIM_LVL_HI: begin
                        count_d = ers_a_q ? `HLTM_RST_COUNT : count_inc;
                    end
                    `HLTM_M_OS_RISE, `HLTM_M_OS_FALL, `HLTM_M_OS_ANY: begin
                        // 1001 rise, 1010 fall, 1011 either: low bits map onto kinds
                        if (started_q)
                            count_d = count_inc;
                        else if (edge_hit(mode_q[1:0] == 2'h3 ? `HLTM_EDGE_ANY : mode_q[1:0],
                                          ers_rise, ers_fall))
                            started_d = 1'b1;
                    end
                    `HLTM_M_OSL_RISE, `HLTM_M_OSL_FALL: begin
                        if (!started_q) begin
                            if (edge_hit(mode_q[0] ? `HLTM_EDGE_FALL : `HLTM_EDGE_RISE, ers_rise, ers_fall))
                                started_d = 1'b1;
                        end else if (edge_hit(mode_q[0] ? `HLTM_EDGE_FALL : `HLTM_EDGE_RISE,
                                              ers_rise, ers_fall)) begin
                            count_d = `HLTM_RST_COUNT;
                            hold_d  = `HLTM_RESTART_TICKS - 2'h1;
                        end else if (hold_q != 2'h0) begin
                            hold_d  = hold_q - 2'h1;
                        end else begin
                            count_d = count_inc;
                        end
                    end
                    `HLTM_M_OSV_HI, `HLTM_M_OSV_LO: begin
                        // reset level is high for 1110, low for 1111
                        if (ers_a_q ^ mode_q[0])
                            count_d = `HLTM_RST_COUNT;
                        else if (started_q)
                            count_d = count_inc;
                        else if ((ers_b_q ^ mode_q[0]) || (count_q != `HLTM_RST_COUNT))
                            started_d = 1'b1;
                    end
                    `HLTM_M_OS_SW: begin
                        count_d = count_inc;
                    end
                    default: begin
                        count_d = count_inc;
                    end
                endcase
            end
        end
    end

    // timer state; a bus write of the count takes priority over the tick
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q   <= `HLTM_RST_COUNT;
            started_q <= 1'b0;
            hold_q    <= 2'h0;
        end else begin
            count_q   <= wr_count ? writedata[7:0] : count_d;
            started_q <= started_d;
            hold_q    <= hold_d;
        end
    end

    // run bit: software sets or clears; hardware clears it on a one-shot match.
    // a software write in the same cycle wins so a fresh start is never lost
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (wr_ctrl) begin
            run_q <= writedata[`HLTM_CTRL_RUN_BIT];
        end else if (hw_stop) begin
            run_q <= 1'b0;
        end
    end

    // run bit reaches the counter only after two timer ticks
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_p1_q <= 1'b0;
            run_p2_q <= 1'b0;
        end else if (hw_stop) begin
            run_p1_q <= 1'b0;
            run_p2_q <= 1'b0;
        end else if (tick_en) begin
            run_p1_q <= run_q;
            run_p2_q <= run_p1_q;
        end
    end
    assign run_eff = run_p2_q;

    // postscaler counts matches; cleared by count or control writes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            post_cnt_q <= `HLTM_RST_POST;
        end else if (wr_ctrl || wr_count) begin
            post_cnt_q <= `HLTM_RST_POST;
        end else if (match_evt) begin
            post_cnt_q <= (post_cnt_q == post_sel_q) ? `HLTM_RST_POST : post_cnt_q + 4'h1;
        end
    end

    // pulse is refreshed every tick, so it stands exactly one timer clock period
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q <= 1'b0;
        end else if (tick_en) begin
            pulse_q <= match_evt && (post_cnt_q == post_sel_q);
        end
    end

    // ask the clock unit to keep an internal oscillator alive while asleep
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            keep_osc_q <= 1'b0;
        end else begin
            keep_osc_q <= sleep_s & is_int_osc(clk_sel_q);
        end
    end

    // software-written configuration
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_q   <= `HLTM_RST_PERIOD;
            mode_q     <= `HLTM_RST_MODE;
            prescaler_sync_select_q    <= 1'b0;
            post_sel_q <= `HLTM_RST_POST;
            clk_sel_q  <= `HLTM_RST_CLKSEL;
        end else if (wr_en) begin
            case (address)
                `HLTM_OFS_CTRL: begin
                    post_sel_q <= writedata[`HLTM_CTRL_POST_MSB:0];
                end
                `HLTM_OFS_MODE: begin
                    mode_q  <= writedata[`HLTM_MODE_MSB:0];
                    prescaler_sync_select_q <= writedata[`HLTM_MODE_PRESCALER_SYNC_SELECT_BIT];
                end
                `HLTM_OFS_PERIOD: begin
                    period_q <= writedata[7:0];
                end
                `HLTM_OFS_CLKSEL: begin
                    clk_sel_q <= writedata[`HLTM_CLKSEL_MSB:0];
                end
                default: begin
                    clk_sel_q <= clk_sel_q;
                end
            endcase
        end
    end

    // read mux; unmapped addresses read as zero
    always @* begin
        rdata_d = 32'h00000000;
        case (address)
            `HLTM_OFS_CTRL:   rdata_d = {24'h000000, run_q, 3'h0, post_sel_q};
            `HLTM_OFS_MODE:   rdata_d = {24'h000000, prescaler_sync_select_q, 3'h0, mode_q};
            `HLTM_OFS_COUNT:  rdata_d = {24'h000000, count_q};
            `HLTM_OFS_PERIOD: rdata_d = {24'h000000, period_q};
            `HLTM_OFS_CLKSEL: rdata_d = {29'h00000000, clk_sel_q};
            `HLTM_OFS_STATUS: rdata_d = {28'h0000000, sleep_s, ers_a_q, started_q, run_eff};
            default:          rdata_d = 32'h00000000;
        endcase
    end

    // one wait state: waitrequest drops for the cycle after a request is seen
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q <= ~((read | write) & wait_q);
            if (read & wait_q)
                rdata_q <= rdata_d;
        end
    end

    assign readdata           = rdata_q;
    assign waitrequest        = wait_q;
    assign timer_count        = count_q;
    assign period_match_pulse = pulse_q;
    assign osc_keep_running   = keep_osc_q;
    // access is the accepted-request strobe, kept for clarity of the decode
    wire unused_access = access;
endmodule // hltm_timer

// [verification/hltm_ext_model.sv]
// Purpose: partner model: free running timer clock pin and external reset source
// Assumes: the bench sets the wanted external level on ext_lvl
// Notes:   both outputs change just after a clk rise, never between edges
`timescale 1ns/100ps
module hltm_ext_model #(
    parameter HALF = 8
) (
    input  wire clk,
    input  wire ext_lvl,
    output reg  timer_clock,
    output reg  ext_reset_input
);
    reg [7:0] div_q = 8'h00;

    initial timer_clock = 1'b0;
    initial ext_reset_input = 1'b0;

    // oscillator ignores the timer reset, as a real clock pin would
    always @(posedge clk) begin
        div_q <= (div_q == HALF - 1) ? 8'h00 : div_q + 8'h01;
        if (div_q == HALF - 1)
            timer_clock <= ~timer_clock;
        ext_reset_input <= ext_lvl;
    end
endmodule // hltm_ext_model

// [verification/hltm_timer_asserts.sv]
// Purpose: port assertions for hltm_timer
// Assumes: timer clock phases last at least three clk each
// Notes:   bound to every hltm_timer instance at the foot
`timescale 1ns/100ps
module hltm_timer_chk (
    input wire        clk,
    input wire        nrst,
    input wire [4:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [3:0]  byteenable,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire        timer_clock,
    input wire        ext_reset_input,
    input wire        sleep_active,
    input wire [7:0]  timer_count,
    input wire        period_match_pulse,
    input wire        osc_keep_running
);
    reg       rs_q = 1'b0;
    reg       tc_q;
    reg       wr_q;
    reg [3:0] since_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // remembers reset at the last edge, so the first edge of the run is never judged
    always @(posedge clk)
        rs_q <= !nrst;

    // clk cycles since the raw timer clock rose; saturates so old ticks never look fresh
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tc_q    <= 1'b0;
            wr_q    <= 1'b0;
            since_q <= 4'hF;
        end else begin
            tc_q    <= timer_clock;
            wr_q    <= write;
            since_q <= (timer_clock && !tc_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
        end
    end

    a_reset_clear: assert property (disable iff (1'b0)
        !nrst && rs_q |-> timer_count == 8'h00 && !period_match_pulse)
        else $error("count or pulse not clear in reset");
    a_count_step: assert property ($changed(timer_count) && !wr_q |->
        timer_count == $past(timer_count) + 8'h01 || timer_count == 8'h00)
        else $error("count moved by other than one step");
    a_count_tick: assert property ($changed(timer_count) && !wr_q |-> since_q <= 4'h7)
        else $error("count moved away from a timer tick");
    a_match_zero: assert property ($rose(period_match_pulse) |-> timer_count == 8'h00)
        else $error("match pulse without count at zero");
    a_pulse_hold: assert property ($rose(period_match_pulse) |-> period_match_pulse [*6])
        else $error("match pulse shorter than a timer period");
    a_pulse_end: assert property ($fell(period_match_pulse) |-> since_q <= 4'h7)
        else $error("match pulse ended away from a timer tick");
    a_osc_awake: assert property (!sleep_active [*6] |-> !osc_keep_running)
        else $error("oscillator kept on while awake");
    a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus access not answered in one cycle");
    a_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_read_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");

    c_match: cover property ($rose(period_match_pulse));
    c_read: cover property (read && !waitrequest);
    c_osc: cover property ($rose(osc_keep_running));
endmodule // hltm_timer_chk

bind hltm_timer hltm_timer_chk chk_u (.clk, .nrst, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .timer_clock, .ext_reset_input, .sleep_active, .timer_count,
    .period_match_pulse, .osc_keep_running);

// [verification/tb.sv]
// Purpose: self-checking bench for hltm_timer over its Avalon-MM port
// Assumes: a timer tick every 16 clk from the partner model
// Notes:   the count is looked at six clk after a timer clock rise, when it is settled
`timescale 1ns/100ps
`include "hltm_defines.vh"
module tb;
    reg         clk = 1'b0;
    reg         nrst = 1'b0;
    reg  [4:0]  address = 5'h00;
    reg         read = 1'b0;
    reg         write = 1'b0;
    reg  [31:0] writedata = 32'h00000000;
    reg  [3:0]  byteenable = 4'hF;
    reg         sleep_active = 1'b0;
    reg         ext_lvl = 1'b0;
    wire [31:0] readdata;
    wire        waitrequest;
    wire        timer_clock;
    wire        ext_reset_input;
    wire        period_match_pulse;
    wire        osc_keep_running;
    wire [7:0]  timer_count;
    reg  [31:0] rd;
    reg  [7:0]  c0;
    integer     err_total = 0;
    integer     compares = 0;
    integer     i;

    // 10 MHz system clock
    always #50 clk = ~clk;

    hltm_ext_model ext_u (.clk, .ext_lvl, .timer_clock, .ext_reset_input);
    hltm_timer dut_u (.clk, .nrst, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .timer_clock, .ext_reset_input, .sleep_active, .timer_count,
        .period_match_pulse, .osc_keep_running);

    task conclude;
        begin
            $display("compares %0d, errors %0d", compares, err_total);
            if (err_total == 0 && compares > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // one bus access; holds everything until waitrequest is seen low at an edge
    task acc(input wr, input [4:0] a, input [7:0] d);
        integer n;
        begin
            n = 0;
            address <= a;
            writedata <= {24'h000000, d};
            read <= !wr;
            write <= wr;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (waitrequest !== 1'b0 && n < 20);
            if (n >= 20)
                err_total = err_total + 1;
            rd = readdata;
            read <= 1'b0;
            write <= 1'b0;
            @(posedge clk);
        end
    endtask

    task wr(input [4:0] a, input [7:0] d);
        acc(1'b1, a, d);
    endtask

    task rchk(input [4:0] a, input [7:0] e);
        begin
            acc(1'b0, a, 8'h00);
            chk(rd, {24'h000000, e});
        end
    endtask

    // n timer ticks, then wait until the count has settled
    task tk(input integer n);
        begin
            repeat (n) @(posedge timer_clock);
            repeat (6) @(posedge clk);
        end
    endtask

    // does the count move across one tick
    task mv(input e);
        begin
            c0 = timer_count;
            tk(1);
            chk(32'(timer_count !== c0), 32'(e));
        end
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(`HLTM_OFS_COUNT, `HLTM_RST_COUNT);
        rchk(`HLTM_OFS_PERIOD, `HLTM_RST_PERIOD);
        rchk(5'h1C, 8'h00);
        byteenable <= 4'hE;
        wr(`HLTM_OFS_PERIOD, 8'h03);
        byteenable <= 4'hF;
        rchk(`HLTM_OFS_PERIOD, 8'hFF);
        wr(`HLTM_OFS_PERIOD, 8'h03);
        wr(`HLTM_OFS_CTRL, 8'h80);
        i = 0;
        while (timer_count !== 8'h01 && i < 20) begin
            tk(1);
            i = i + 1;
        end
        chk({24'h0, timer_count}, 32'h1);
        for (i = 2; i < 6; i = i + 1) begin
            tk(1);
            chk({23'h0, period_match_pulse, timer_count}, {23'h0, i % 4 == 0, 8'(i % 4)});
        end
        wr(`HLTM_OFS_CTRL, 8'h00);
        tk(3);
        mv(1'b0);
        // hardware gate: high then low external level
        for (i = 1; i < 3; i = i + 1) begin
            wr(`HLTM_OFS_MODE, 8'(i));
            wr(`HLTM_OFS_CTRL, 8'h80);
            ext_lvl <= 1'b1;
            tk(3);
            mv(i == 2);
            ext_lvl <= 1'b0;
            tk(3);
            mv(i == 1);
        end
        // edge limit: a small count after an edge means it was reset
        wr(`HLTM_OFS_PERIOD, 8'hC8);
        for (i = 3; i < 6; i = i + 1) begin
            ext_lvl <= 1'b1;
            wr(`HLTM_OFS_MODE, 8'(i));
            tk(6);
            ext_lvl <= 1'b0;
            tk(3);
            chk(32'(timer_count < 8'h03), 32'(i != 4));
            ext_lvl <= 1'b1;
            tk(3);
            chk(32'(timer_count < 8'h03), 32'(i != 5));
        end
        for (i = 6; i < 8; i = i + 1) begin
            ext_lvl <= (i == 7);
            wr(`HLTM_OFS_MODE, 8'(i));
            tk(4);
            chk({24'h0, timer_count}, 32'h0);
            ext_lvl <= (i == 6);
            tk(3);
            mv(1'b1);
        end
        wr(`HLTM_OFS_CTRL, 8'h00);
        tk(3);
        ext_lvl <= 1'b1;
        tk(4);
        chk(32'(timer_count != 8'h00), 32'h1);
        // software one-shot, then a rerun by software
        ext_lvl <= 1'b0;
        wr(`HLTM_OFS_PERIOD, 8'h03);
        wr(`HLTM_OFS_MODE, 8'h08);
        wr(`HLTM_OFS_COUNT, 8'h00);
        wr(`HLTM_OFS_CTRL, 8'h80);
        tk(10);
        rchk(`HLTM_OFS_CTRL, 8'h00);
        mv(1'b0);
        wr(`HLTM_OFS_CTRL, 8'h80);
        tk(3);
        mv(1'b1);
        tk(4);
        wr(`HLTM_OFS_MODE, 8'h09);
        wr(`HLTM_OFS_CTRL, 8'h80);
        tk(4);
        chk({24'h0, timer_count}, 32'h0);
        ext_lvl <= 1'b1;
        tk(3);
        mv(1'b1);
        tk(6);
        rchk(`HLTM_OFS_CTRL, 8'h00);
        // sleep with and without prescaler sync
        wr(`HLTM_OFS_MODE, 8'h80);
        wr(`HLTM_OFS_CTRL, 8'h80);
        wr(`HLTM_OFS_CLKSEL, {5'h00, `HLTM_CS_LFOSC});
        tk(3);
        sleep_active <= 1'b1;
        tk(2);
        mv(1'b0);
        chk({31'h0, osc_keep_running}, 32'h1);
        wr(`HLTM_OFS_MODE, 8'h00);
        tk(2);
        mv(1'b1);
        sleep_active <= 1'b0;
        tk(1);
        chk({31'h0, osc_keep_running}, 32'h0);
        // limit one-shot: first rising edge starts, later ones reset and pause
        ext_lvl <= 1'b0;
        wr(`HLTM_OFS_PERIOD, 8'hC8);
        wr(`HLTM_OFS_MODE, 8'h0C);
        wr(`HLTM_OFS_COUNT, 8'h00);
        tk(4);
        chk({24'h0, timer_count}, 32'h0);
        ext_lvl <= 1'b1;
        tk(3);
        mv(1'b1);
        ext_lvl <= 1'b0;
        tk(3);
        ext_lvl <= 1'b1;
        tk(2);
        chk({24'h0, timer_count}, 32'h0);
        mv(1'b0);
        mv(1'b1);
        // level one-shot: high level holds the count, release lets it run
        wr(`HLTM_OFS_MODE, 8'h0E);
        tk(3);
        chk({24'h0, timer_count}, 32'h0);
        ext_lvl <= 1'b0;
        tk(3);
        mv(1'b1);
        conclude;
    end

    // watchdog: the sequence needs well under 400 us of ticks and bus cycles
    initial begin
        #2000000;
        err_total = err_total + 1;
        conclude;
    end
endmodule // tb
